//--- core/cbls_addr_gen.sv
// Address generator for pointer-based data memory accesses.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
`default_nettype none
module cbls_addr_gen (
	input  wire logic [15:0]              ptr_val,
	input  wire cbls_pkg::cbls_ptr_mode_type mode,
	input  wire logic [5:0]               disp,
	output logic      [15:0]              acc_addr,
	output logic      [15:0]              new_ptr,
	output logic                          ptr_upd
);

	logic [15:0] ptr_inc;
	logic [15:0] ptr_dec;
	logic [15:0] ptr_off;

	// Full 16-bit arithmetic so carries and borrows cross the register pair
	assign ptr_inc = ptr_val + cbls_pkg::PTR_STEP;
	assign ptr_dec = ptr_val - cbls_pkg::PTR_STEP;
	assign ptr_off = ptr_val + {10'h000, disp};

	// Pre-decrement uses the new value, post-increment the old one
	assign acc_addr = (mode == cbls_pkg::PTR_PREDEC) ? ptr_dec :
	                  (mode == cbls_pkg::PTR_DISP)   ? ptr_off : ptr_val;
	assign new_ptr  = (mode == cbls_pkg::PTR_PREDEC) ? ptr_dec : ptr_inc;
	assign ptr_upd  = (mode == cbls_pkg::PTR_PREDEC) || (mode == cbls_pkg::PTR_POSTINC);

endmodule
`default_nettype wire

//--- core/cbls_exec.sv
// Executor for conditional flag branches and register/data-memory transfers.
// Assumes fetch presents one instruction word plus the following word, and that
// data memory returns read data in the same cycle its address and read strobe stand.
// Words offered while READY is low are ignored, so fetch must hold them.
//
// Operation
// - Selected-flag branch: target PC+k+1; 1/2 cycles
// - Equal/unequal branches test zero flag
// - Carry one/below and zero/not-below branches test carry
// - Negative/positive branches test negative flag
// - Signed branches test negative XOR overflow
// - Half-carry branches test half-carry flag
// - Transfer-bit branches test T; flags untouched
// - Overflow branches test overflow flag
// - Interrupt-state branches test global interrupt enable
// - Register copy and constant load, one cycle
// - Pointer load, two cycles, optional post-increment
// - Pre-decrement load uses decremented pointer
// - Offset load: Y/Z plus displacement, pointer kept
// - Absolute load from address word, two cycles
// - Pointer store, two cycles, optional post-increment
// - Pre-decrement store writes at decremented pointer
`timescale 1ns/1ps
`default_nettype none
module cbls_exec (
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	input  wire logic        INSTR_VALID,
	input  wire logic [15:0] INSTR_WORD,
	input  wire logic [15:0] INSTR_EXT,
	input  wire logic [7:0]  STATUS_FLAGS,
	input  wire logic [7:0]  DMEM_RDATA,
	input  wire logic [4:0]  RF_PEEK_ADDR,
	output logic             READY,
	output logic      [15:0] PC,
	output logic      [15:0] DMEM_ADDR,
	output logic      [7:0]  DMEM_WDATA,
	output logic             DMEM_RE,
	output logic             DMEM_WE,
	output logic      [7:0]  RF_PEEK_DATA,
	output logic             BRANCH_TAKEN,
	output logic             INSTR_DONE,
	output logic             INSTR_UNKNOWN
);

	// ****************************************
	// State
	// ****************************************
	cbls_pkg::cbls_state_type state_ff;
	cbls_pkg::cbls_state_type nxt_state;
	logic [7:0]  rf_ff [cbls_pkg::RF_DEPTH];
	logic        ready_ff;
	logic [15:0] pc_ff;
	logic [15:0] daddr_ff;
	logic [7:0]  wdata_ff;
	logic        re_ff;
	logic        we_ff;
	logic [4:0]  dst_ff;
	logic [7:0]  peek_ff;
	logic        taken_ff;
	logic        done_ff;
	logic        unknown_ff;

	// ****************************************
	// Field decode
	// ****************************************
	logic [15:0] w;
	logic        accept;
	assign w      = INSTR_WORD;
	assign accept = INSTR_VALID && ready_ff;

	logic        is_flag_br;
	logic        is_copy;
	logic        is_const;
	logic        is_ptr_xfer;
	logic        is_offset;
	assign is_flag_br  = (w[15:11] == cbls_pkg::OPC_FLAG_BRANCH);
	assign is_copy     = (w[15:10] == cbls_pkg::OPC_COPY);
	assign is_const    = (w[15:12] == cbls_pkg::OPC_CONST);
	assign is_ptr_xfer = (w[15:10] == cbls_pkg::OPC_PTR_XFER);
	assign is_offset   = (w[15:14] == cbls_pkg::OPC_OFFSET) && !w[12];

	logic [4:0]  reg_d;
	logic [4:0]  reg_r;
	logic [4:0]  reg_k;
	logic [7:0]  const_k;
	logic [3:0]  sub_op;
	logic        xfer_store;
	logic [5:0]  disp_q;
	assign reg_d      = w[8:4];
	assign reg_r      = {w[9], w[3:0]};
	assign reg_k      = {1'b1, w[7:4]};
	assign const_k    = {w[11:8], w[3:0]};
	assign sub_op     = w[3:0];
	assign xfer_store = w[9];
	assign disp_q     = {w[13], w[11:10], w[2:0]};

	// ****************************************
	// Branch condition
	// ****************************************
	logic [7:0]  test_flags;
	logic        flag_bit;
	logic        br_cond;
	logic [15:0] br_offset;
	logic [15:0] br_target;

	// Signed position is formed from N and V so the signed branches never see a stale S
	assign test_flags = {STATUS_FLAGS[7:cbls_pkg::FLAG_S+1],
	                     STATUS_FLAGS[cbls_pkg::FLAG_N] ^ STATUS_FLAGS[cbls_pkg::FLAG_V],
	                     STATUS_FLAGS[cbls_pkg::FLAG_S-1:0]};
	// Every named branch is this one test with a fixed flag index and polarity
	assign flag_bit   = test_flags[w[2:0]];
	assign br_cond    = w[10] ? !flag_bit : flag_bit;
	assign br_offset  = {{9{w[9]}}, w[9:3]};
	assign br_target  = pc_ff + br_offset + cbls_pkg::PC_STEP_ONE;

	// ****************************************
	// Pointer transfer decode
	// ****************************************
	logic        sub_ok;
	logic        sub_abs;
	logic        is_ptr_ld;
	logic        is_ptr_st;
	logic        is_abs_ld;
	logic        is_off_ld;
	logic        is_off_st;
	assign sub_ok = (sub_op == cbls_pkg::SUB_Z_INC)   || (sub_op == cbls_pkg::SUB_Z_DEC) ||
	                (sub_op == cbls_pkg::SUB_Y_INC)   || (sub_op == cbls_pkg::SUB_Y_DEC) ||
	                (sub_op == cbls_pkg::SUB_X_PLAIN) || (sub_op == cbls_pkg::SUB_X_INC) ||
	                (sub_op == cbls_pkg::SUB_X_DEC);
	assign sub_abs   = (sub_op == cbls_pkg::SUB_ABSOLUTE);
	assign is_ptr_ld = is_ptr_xfer && !xfer_store && sub_ok;
	assign is_ptr_st = is_ptr_xfer && xfer_store && sub_ok;
	assign is_abs_ld = is_ptr_xfer && !xfer_store && sub_abs;
	assign is_off_ld = is_offset && !xfer_store;
	// Only the zero-displacement store (plain Y or Z) is handled here
	assign is_off_st = is_offset && xfer_store && (disp_q == 6'h00);

	logic [4:0]                  ptr_lo;
	cbls_pkg::cbls_ptr_mode_type ptr_mode;
	assign ptr_lo = is_offset ? (w[3] ? cbls_pkg::PTR_Y_LO : cbls_pkg::PTR_Z_LO) :
	                (sub_op[3:2] == 2'h3) ? cbls_pkg::PTR_X_LO :
	                sub_op[3] ? cbls_pkg::PTR_Y_LO : cbls_pkg::PTR_Z_LO;
	assign ptr_mode = is_offset ? cbls_pkg::PTR_DISP :
	                  (sub_op == cbls_pkg::SUB_X_PLAIN) ? cbls_pkg::PTR_PLAIN :
	                  sub_op[0] ? cbls_pkg::PTR_POSTINC : cbls_pkg::PTR_PREDEC;

	// Pointer pair read: high byte sits one index above the low byte
	logic [4:0]  ptr_hi;
	logic [15:0] ptr_val;
	assign ptr_hi  = ptr_lo + 5'h01;
	assign ptr_val = {rf_ff[ptr_hi], rf_ff[ptr_lo]};

	logic [15:0] acc_addr;
	logic [15:0] new_ptr;
	logic        ptr_upd;

	cbls_addr_gen u_addr_gen (
		.ptr_val  (ptr_val),
		.mode     (ptr_mode),
		.disp     (disp_q),
		.acc_addr (acc_addr),
		.new_ptr  (new_ptr),
		.ptr_upd  (ptr_upd)
	);

	// ****************************************
	// Instruction classes
	// ****************************************
	logic mem_load;
	logic mem_store;
	logic mem_op;
	logic single_op;
	logic known;
	logic issue_mem;
	assign mem_load  = is_ptr_ld || is_off_ld || is_abs_ld;
	assign mem_store = is_ptr_st || is_off_st;
	assign mem_op    = mem_load || mem_store;
	assign single_op = is_copy || is_const || (is_flag_br && !br_cond);
	// Words matching no pattern raise INSTR_UNKNOWN and change nothing else
	assign known     = mem_op || is_copy || is_const || is_flag_br;
	assign issue_mem = accept && mem_op;

	// ****************************************
	// Next-state values
	// ****************************************
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			cbls_pkg::ST_IDLE: begin
				if (accept && mem_op) begin
					nxt_state = cbls_pkg::ST_MEM;
				end else if (accept && is_flag_br && br_cond) begin
					nxt_state = cbls_pkg::ST_BRANCH;
				end
			end
			cbls_pkg::ST_MEM:    nxt_state = cbls_pkg::ST_IDLE;
			cbls_pkg::ST_BRANCH: nxt_state = cbls_pkg::ST_IDLE;
			default:             nxt_state = cbls_pkg::ST_IDLE;
		endcase
	end

	// Busy only for the second cycle of a two-cycle operation
	logic nxt_ready;
	assign nxt_ready = (nxt_state == cbls_pkg::ST_IDLE);

	logic [15:0] nxt_pc;
	logic [15:0] pc_seq;
	assign pc_seq = is_abs_ld ? (pc_ff + cbls_pkg::PC_STEP_TWO) : (pc_ff + cbls_pkg::PC_STEP_ONE);
	// Unknown words leave the counter for the rest of the core to move
	assign nxt_pc = !accept || !known   ? pc_ff :
	                (is_flag_br && br_cond) ? br_target : pc_seq;

	logic [15:0] nxt_daddr;
	logic        nxt_re;
	logic        nxt_we;
	assign nxt_daddr = is_abs_ld ? INSTR_EXT : acc_addr;
	assign nxt_re    = accept && mem_load;
	assign nxt_we    = accept && mem_store;

	// ****************************************
	// Register file write ports
	// ****************************************
	logic       ptr_we;
	logic       dat_we;
	logic [4:0] dat_idx;
	logic [7:0] dat_val;
	// Pointer write happens at issue; memory still sees the address captured beforehand
	assign ptr_we  = accept && mem_op && !is_abs_ld && ptr_upd;
	assign dat_we  = (accept && (is_copy || is_const)) || ((state_ff == cbls_pkg::ST_MEM) && re_ff);
	assign dat_idx = (state_ff == cbls_pkg::ST_MEM) ? dst_ff : (is_const ? reg_k : reg_d);
	assign dat_val = (state_ff == cbls_pkg::ST_MEM) ? DMEM_RDATA :
	                 is_const ? const_k : rf_ff[reg_r];

	// Writes never collide: pointer updates only at issue, loaded data only in the
	// second cycle, and copy/constant never touch a pointer in the same cycle.
	// Loading into the pointer being stepped is left undefined, as software must avoid it.
	genvar gi;
	generate
		for (gi = 0; gi < cbls_pkg::RF_DEPTH; gi++) begin : g_rf
			logic sel_lo;
			logic sel_hi;
			logic sel_dat;
			assign sel_lo  = ptr_we && (ptr_lo == 5'(gi));
			assign sel_hi  = ptr_we && (ptr_hi == 5'(gi));
			assign sel_dat = dat_we && (dat_idx == 5'(gi));

			always_ff @(posedge CLK) begin
				if (SYS_RST) begin
					rf_ff[gi] <= cbls_pkg::RF_RESET;
				end else if (sel_lo) begin
					rf_ff[gi] <= new_ptr[7:0];
				end else if (sel_hi) begin
					rf_ff[gi] <= new_ptr[15:8];
				end else if (sel_dat) begin
					rf_ff[gi] <= dat_val;
				end
			end
		end
	endgenerate

	// ****************************************
	// Sequencing and outputs
	// ****************************************
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state_ff <= cbls_pkg::ST_IDLE;
			ready_ff <= 1'b1;
			pc_ff    <= cbls_pkg::PC_RESET;
		end else begin
			state_ff <= nxt_state;
			ready_ff <= nxt_ready;
			pc_ff    <= nxt_pc;
		end
	end

	// Strobes are one-cycle pulses; nxt_re and nxt_we are already low off issue
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			re_ff <= 1'b0;
			we_ff <= 1'b0;
		end else begin
			re_ff <= nxt_re;
			we_ff <= nxt_we;
		end
	end

	// Address, store data and destination are held after issue for visibility
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			daddr_ff <= cbls_pkg::ADDR_RESET;
			wdata_ff <= cbls_pkg::RF_RESET;
			dst_ff   <= 5'h00;
		end else if (issue_mem) begin
			daddr_ff <= nxt_daddr;
			wdata_ff <= rf_ff[reg_d];
			dst_ff   <= reg_d;
		end
	end

	// Completion and status pulses, each standing one cycle
	logic nxt_taken;
	logic nxt_done;
	logic nxt_unknown;
	assign nxt_taken   = accept && is_flag_br && br_cond;
	assign nxt_done    = (accept && single_op) || (state_ff != cbls_pkg::ST_IDLE);
	assign nxt_unknown = accept && !known;

	// Flags are inputs only; nothing here can alter them
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			taken_ff   <= 1'b0;
			done_ff    <= 1'b0;
			unknown_ff <= 1'b0;
		end else begin
			taken_ff   <= nxt_taken;
			done_ff    <= nxt_done;
			unknown_ff <= nxt_unknown;
		end
	end

	// Debug read is registered so RF_PEEK_DATA comes straight from a flip-flop
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			peek_ff <= cbls_pkg::RF_RESET;
		end else begin
			peek_ff <= rf_ff[RF_PEEK_ADDR];
		end
	end

	assign READY         = ready_ff;
	assign PC            = pc_ff;
	assign DMEM_ADDR     = daddr_ff;
	assign DMEM_WDATA    = wdata_ff;
	assign DMEM_RE       = re_ff;
	assign DMEM_WE       = we_ff;
	assign RF_PEEK_DATA  = peek_ff;
	assign BRANCH_TAKEN  = taken_ff;
	assign INSTR_DONE    = done_ff;
	assign INSTR_UNKNOWN = unknown_ff;

endmodule
`default_nettype wire

//--- core/cbls_pkg.sv
// Constants, opcode patterns and types for the branch and load/store executor.
// Assumes a single core clock and a 16-bit instruction word fed by the fetch stage.
package cbls_pkg;

	// ****************************************
	// Widths and sizes
	// ****************************************
	localparam int unsigned PC_W      = 16;
	localparam int unsigned ADDR_W    = 16;
	localparam int unsigned DATA_W    = 8;
	localparam int unsigned RF_DEPTH  = 32;
	localparam int unsigned RIDX_W    = 5;

	// ****************************************
	// Reset values and steps
	// ****************************************
	localparam logic [PC_W-1:0]   PC_RESET     = 16'h0000;
	localparam logic [DATA_W-1:0] RF_RESET     = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RESET   = 16'h0000;
	localparam logic [PC_W-1:0]   PC_STEP_ONE  = 16'h0001;
	localparam logic [PC_W-1:0]   PC_STEP_TWO  = 16'h0002;
	localparam logic [ADDR_W-1:0] PTR_STEP     = 16'h0001;

	// ****************************************
	// Pointer pair base indices (low byte; high byte is base + 1)
	// ****************************************
	localparam logic [RIDX_W-1:0] PTR_X_LO = 5'h1a;
	localparam logic [RIDX_W-1:0] PTR_Y_LO = 5'h1c;
	localparam logic [RIDX_W-1:0] PTR_Z_LO = 5'h1e;

	// ****************************************
	// Opcode patterns
	// ****************************************
	localparam logic [4:0] OPC_FLAG_BRANCH = 5'h1e;
	localparam logic [5:0] OPC_COPY        = 6'h0b;
	localparam logic [3:0] OPC_CONST       = 4'he;
	localparam logic [5:0] OPC_PTR_XFER    = 6'h24;
	localparam logic [1:0] OPC_OFFSET      = 2'h2;

	// Low nibble of pointer transfers
	localparam logic [3:0] SUB_ABSOLUTE = 4'h0;
	localparam logic [3:0] SUB_Z_INC    = 4'h1;
	localparam logic [3:0] SUB_Z_DEC    = 4'h2;
	localparam logic [3:0] SUB_Y_INC    = 4'h9;
	localparam logic [3:0] SUB_Y_DEC    = 4'ha;
	localparam logic [3:0] SUB_X_PLAIN  = 4'hc;
	localparam logic [3:0] SUB_X_INC    = 4'hd;
	localparam logic [3:0] SUB_X_DEC    = 4'he;

	// Status flag positions
	localparam int unsigned FLAG_N = 2;
	localparam int unsigned FLAG_V = 3;
	localparam int unsigned FLAG_S = 4;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		PTR_PLAIN   = 2'h0,
		PTR_POSTINC = 2'h1,
		PTR_PREDEC  = 2'h2,
		PTR_DISP    = 2'h3
	} cbls_ptr_mode_type;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_MEM    = 2'h1,
		ST_BRANCH = 2'h2
	} cbls_state_type;

endpackage

//--- dv/cbls_dmem_model.sv
// Data memory model for the executor's far side.
// Assumes read data is combinational while the read strobe stands.
`timescale 1ns/1ps
`default_nettype none
module cbls_dmem_model (
	input  wire logic        clk,
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        re,
	input  wire logic        we,
	output logic      [7:0]  rdata
);
	// Only 256 bytes: upper address bits alias
	logic [7:0] mem [0:255];
	logic [7:0] last_ff;
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = i[7:0];
		last_ff = 8'h00;
	end
	always @(posedge clk) begin
		if (we) mem[addr[7:0]] <= wdata;
		if (re) last_ff <= mem[addr[7:0]];
	end
	// Unselected: inverse of last value, so a stale sample cannot match
	assign rdata = re ? mem[addr[7:0]] : ~last_ff;
endmodule
`default_nettype wire

//--- dv/cbls_exec_monitor.sv
// Checker on the executor's top-level ports.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module cbls_exec_monitor (
	input wire logic        CLK,
	input wire logic        SYS_RST,
	input wire logic        INSTR_VALID,
	input wire logic [15:0] INSTR_WORD,
	input wire logic [15:0] INSTR_EXT,
	input wire logic [7:0]  STATUS_FLAGS,
	input wire logic        READY,
	input wire logic [15:0] PC,
	input wire logic [15:0] DMEM_ADDR,
	input wire logic        DMEM_RE,
	input wire logic        DMEM_WE,
	input wire logic        BRANCH_TAKEN,
	input wire logic        INSTR_DONE
);
	default clocking mcb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	wire logic        tk  = INSTR_VALID && READY;
	wire logic        br  = INSTR_WORD[15:11] == 5'h1e;
	wire logic [7:0]  fe  = {STATUS_FLAGS[7:5], STATUS_FLAGS[2] ^ STATUS_FLAGS[3], STATUS_FLAGS[3:0]};
	wire logic        hit = fe[INSTR_WORD[2:0]] ^ INSTR_WORD[10];
	wire logic        one = INSTR_WORD[15:10] == 6'h0b || INSTR_WORD[15:12] == 4'he;
	wire logic        mok = INSTR_WORD[3:0] inside {4'h0, 4'h1, 4'h2, 4'h9, 4'ha, 4'hc, 4'hd, 4'he};
	wire logic        ld  = INSTR_WORD[15:9] == 7'h48 && mok;
	wire logic        st  = INSTR_WORD[15:9] == 7'h49 && mok && INSTR_WORD[3:0] != 4'h0;
	wire logic [15:0] tgt = PC + {{9{INSTR_WORD[9]}}, INSTR_WORD[9:3]} + 16'h0001;
	a_br_target: assert property (tk && br && hit |=> PC == $past(tgt) && BRANCH_TAKEN && !READY)
		else $error("taken branch target wrong");
	a_br_skip: assert property (tk && br && !hit |=>
		PC == $past(PC) + 16'h0001 && !BRANCH_TAKEN && INSTR_DONE)
		else $error("untaken branch wrong");
	a_br_two_cycles: assert property (tk && br && hit |=> !READY ##1 READY && INSTR_DONE)
		else $error("taken branch timing wrong");
	a_br_signed: assert property (tk && br && INSTR_WORD[2:0] == 3'h4 |=>
		BRANCH_TAKEN == $past(STATUS_FLAGS[2] ^ STATUS_FLAGS[3] ^ INSTR_WORD[10]))
		else $error("signed branch decision wrong");
	a_single_cycle: assert property (tk && one |=> INSTR_DONE && READY && PC == $past(PC) + 16'h0001)
		else $error("copy or constant not single cycle");
	a_load_strobe: assert property (tk && ld |=>
		DMEM_RE && !DMEM_WE && !READY ##1 READY && INSTR_DONE && !DMEM_RE)
		else $error("load strobe or timing wrong");
	a_store_strobe: assert property (tk && st |=>
		DMEM_WE && !DMEM_RE && !READY ##1 INSTR_DONE && !DMEM_WE)
		else $error("store strobe or timing wrong");
	a_abs_addr: assert property (tk && ld && INSTR_WORD[3:0] == 4'h0 |=>
		DMEM_ADDR == $past(INSTR_EXT) && PC == $past(PC) + 16'h0002)
		else $error("absolute load address wrong");
	a_busy_hold: assert property (!READY |=> $stable(PC))
		else $error("pc moved while busy");
endmodule
bind cbls_exec cbls_exec_monitor cbls_exec_monitor_inst (.CLK(CLK), .SYS_RST(SYS_RST), .INSTR_VALID(INSTR_VALID),
	.INSTR_WORD(INSTR_WORD), .INSTR_EXT(INSTR_EXT), .STATUS_FLAGS(STATUS_FLAGS), .READY(READY), .PC(PC),
	.DMEM_ADDR(DMEM_ADDR), .DMEM_RE(DMEM_RE), .DMEM_WE(DMEM_WE), .BRANCH_TAKEN(BRANCH_TAKEN),
	.INSTR_DONE(INSTR_DONE));
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the branch and load/store executor.
// Assumes the data memory model beside it and the checker bound in.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
	$display("CHECK FAILED t=%0t %s", $time, m); end end
module tb;
	logic        clk, sys_rst, valid, ready, re, we, bt, dn, unk, hit;
	logic        c_bt, c_dn, c_re, c_we, c_unk;
	logic [15:0] word, ext, pc, daddr, c_pc, c_a, pc0;
	logic [7:0]  flags, rdata, wdata, peek_d, c_wd, fl, fe;
	logic [6:0]  k;
	logic [4:0]  peek_a;
	int          num_errors = 0;
	int          n_tests = 0;
	cbls_exec cbls_exec_inst (.CLK(clk), .SYS_RST(sys_rst), .INSTR_VALID(valid), .INSTR_WORD(word),
		.INSTR_EXT(ext), .STATUS_FLAGS(flags), .DMEM_RDATA(rdata), .RF_PEEK_ADDR(peek_a), .READY(ready),
		.PC(pc), .DMEM_ADDR(daddr), .DMEM_WDATA(wdata), .DMEM_RE(re), .DMEM_WE(we), .RF_PEEK_DATA(peek_d),
		.BRANCH_TAKEN(bt), .INSTR_DONE(dn), .INSTR_UNKNOWN(unk));
	cbls_dmem_model cbls_dmem_model_inst (.clk(clk), .addr(daddr), .wdata(wdata), .re(re), .we(we), .rdata(rdata));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task give_verdict;
		$display("errors=%0d checks=%0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// One instruction; captures the cycle after the take, then waits for idle
	task issue(input logic [15:0] w, input logic [15:0] e, input logic [7:0] f);
		int i;
		pc0 = pc;
		@(posedge clk);
		valid <= 1'b1;
		word <= w;
		ext <= e;
		flags <= f;
		@(posedge clk);
		valid <= 1'b0;
		#1;
		{c_bt, c_dn, c_re, c_we, c_unk, c_pc, c_a, c_wd} = {bt, dn, re, we, unk, pc, daddr, wdata};
		for (i = 0; i < 4 && ready !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (ready !== 1'b1) begin
			num_errors++;
			$display("CHECK FAILED t=%0t no return to idle", $time);
			give_verdict();
		end
	endtask
	task peek(input logic [4:0] r, input logic [7:0] x);
		@(posedge clk);
		peek_a <= r;
		@(posedge clk);
		#1;
		`CHK(peek_d, x, "register value")
	endtask
	function automatic logic [15:0] f_ldi(input logic [4:0] d, input logic [7:0] c);
		return {4'he, c[7:4], d[3:0], c[3:0]};
	endfunction
	initial begin
		{sys_rst, valid, word, ext, flags, peek_a} <= {1'b1, 1'b0, 16'h0000, 16'h0000, 8'h00, 5'h00};
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(pc, 16'h0000, "pc after reset")
		// Every flag select, both polarities, each flag at both levels
		for (int f = 0; f < 3; f++) for (int s = 0; s < 8; s++) for (int p = 0; p < 2; p++) begin
			fl = (f == 0) ? 8'h00 : (f == 1) ? 8'hff : 8'h04;
			fe = {fl[7:5], fl[2] ^ fl[3], fl[3:0]};
			hit = fe[s] ^ p[0];
			k = p[0] ? 7'h40 : 7'h3f;
			issue({5'h1e, p[0], k, s[2:0]}, 16'h0000, fl);
			`CHK(c_bt, hit, "branch decision")
			`CHK(c_pc, pc0 + (hit ? {{9{k[6]}}, k} : 16'h0000) + 16'h0001, "branch target")
		end
		issue(f_ldi(5'h10, 8'h3c), 16'h0000, 8'h00);
		`CHK({c_dn, c_pc}, {1'b1, pc0 + 16'h0001}, "constant load")
		issue({6'h0b, 1'b1, 5'h05, 4'h0}, 16'h0000, 8'h00);
		`CHK({c_dn, c_pc}, {1'b1, pc0 + 16'h0001}, "register copy")
		peek(5'h05, 8'h3c);
		issue(f_ldi(5'h1a, 8'hff), 16'h0000, 8'h00);
		issue(f_ldi(5'h14, 8'h81), 16'h0000, 8'h00);
		issue(f_ldi(5'h15, 8'h7e), 16'h0000, 8'h00);
		issue(f_ldi(5'h1c, 8'h10), 16'h0000, 8'h00);
		issue({7'h49, 5'h14, 4'hd}, 16'h0000, 8'h00);
		`CHK({c_we, c_a, c_wd}, {1'b1, 16'h00ff, 8'h81}, "post-increment store")
		peek(5'h1b, 8'h01);
		issue({7'h49, 5'h15, 4'he}, 16'h0000, 8'h00);
		`CHK({c_we, c_a, c_wd}, {1'b1, 16'h00ff, 8'h7e}, "pre-decrement store")
		issue({7'h48, 5'h02, 4'hc}, 16'h0000, 8'h00);
		`CHK({c_re, c_a}, {1'b1, 16'h00ff}, "plain load")
		peek(5'h02, 8'h7e);
		issue({7'h48, 5'h03, 4'he}, 16'h0000, 8'h00);
		`CHK(c_a, 16'h00fe, "pre-decrement load")
		peek(5'h03, 8'hfe);
		issue({7'h48, 5'h04, 4'hd}, 16'h0000, 8'h00);
		`CHK(c_a, 16'h00fe, "post-increment load")
		peek(5'h1a, 8'hff);
		issue({4'ha, 2'h3, 1'b0, 5'h06, 1'b1, 3'h7}, 16'h0000, 8'h00);
		`CHK(c_a, 16'h004f, "offset load address")
		peek(5'h1c, 8'h10);
		peek(5'h06, 8'h4f);
		issue({7'h48, 5'h07, 4'h0}, 16'h1234, 8'h00);
		`CHK({c_a, c_pc}, {16'h1234, pc0 + 16'h0002}, "absolute load")
		peek(5'h07, 8'h34);
		// Z and Y forms, with borrow and carry across the register pair
		issue(f_ldi(5'h1f, 8'h01), 16'h0000, 8'h00);
		issue({7'h41, 5'h10, 4'h0}, 16'h0000, 8'h00);
		`CHK({c_we, c_a, c_wd}, {1'b1, 16'h0100, 8'h3c}, "plain Z store")
		issue({7'h48, 5'h08, 4'h2}, 16'h0000, 8'h00);
		`CHK({c_re, c_a}, {1'b1, 16'h00ff}, "pre-decrement Z load")
		peek(5'h1f, 8'h00);
		peek(5'h08, 8'h7e);
		issue({7'h48, 5'h09, 4'h1}, 16'h0000, 8'h00);
		`CHK(c_a, 16'h00ff, "post-increment Z load")
		peek(5'h1f, 8'h01);
		issue({7'h49, 5'h10, 4'h9}, 16'h0000, 8'h00);
		`CHK({c_we, c_a, c_wd}, {1'b1, 16'h0010, 8'h3c}, "post-increment Y store")
		issue({7'h48, 5'h0a, 4'ha}, 16'h0000, 8'h00);
		`CHK(c_a, 16'h0010, "pre-decrement Y load")
		peek(5'h0a, 8'h3c);
		issue({2'h2, 1'b0, 1'b0, 2'h0, 1'b0, 5'h0b, 1'b0, 3'h1}, 16'h0000, 8'h00);
		`CHK(c_a, 16'h0101, "offset Z load address")
		peek(5'h0b, 8'h01);
		issue({7'h49, 5'h07, 4'h0}, 16'h0000, 8'h00);
		`CHK({c_unk, c_we, c_pc}, {1'b1, 1'b0, pc0}, "unhandled word")
		give_verdict();
	end
endmodule
`default_nettype wire
